// ===== hw/prlk_key_seq.sv
`timescale 1ns/100ps
`default_nettype none
`include "prlk_params.svh"

module prlk_key_seq
  import prlk_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       key_wr_i,
  input  wire prlk_data_t key_data_i,
  output logic            unlocked_o,
  output prlk_data_t      status_o
);

  prlk_key_state_e state_reg;
  prlk_key_state_e state_next;

  // ----------------------------------------------------------------
  // key sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (key_wr_i) begin
      case (state_reg)
        KEY_LOCKED: begin
          if (key_data_i == `PRLK_KEY_FIRST) begin
            state_next = KEY_HALF;
          end
        end
        KEY_HALF: begin
          // a wrong second word restarts the sequence
          if (key_data_i == `PRLK_KEY_SECOND) begin
            state_next = KEY_OPEN;
          end else begin
            state_next = KEY_LOCKED;
          end
        end
        default: begin
          state_next = KEY_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= KEY_LOCKED;
    end else begin
      state_reg <= state_next;
    end
  end

  assign unlocked_o = (state_reg == KEY_OPEN);

  // status word seen on a key read
  always_comb begin
    case (state_reg)
      KEY_HALF: status_o = `PRLK_STAT_HALF;
      KEY_OPEN: status_o = `PRLK_STAT_OPEN;
      default:  status_o = `PRLK_STAT_LOCKED;
    endcase
  end

endmodule
`default_nettype wire

// ===== hw/prlk_params.svh
`ifndef PRLK_PARAMS_SVH
`define PRLK_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define PRLK_ADDR_W      16
`define PRLK_DATA_W      32
`define PRLK_SLOT_W      4
`define PRLK_NGRP        15

// ----------------------------------------------------------------
// address map: slot field is the top nibble, slot f is this unit
// ----------------------------------------------------------------
`define PRLK_SLOT_HI     15
`define PRLK_SLOT_LO     12
`define PRLK_SLOT_SELF   4'hf
`define PRLK_OFS_HI      11
`define PRLK_OFS_LO      0
`define PRLK_OFS_KEY     12'h000
`define PRLK_OFS_MASK    12'h004
`define PRLK_OFS_DBGRUN  12'h008

// ----------------------------------------------------------------
// key sequence and reset values (arbitrary implementation choices)
// ----------------------------------------------------------------
`define PRLK_KEY_FIRST   32'h000000a5
`define PRLK_KEY_SECOND  32'h000000f1
`define PRLK_MASK_RST    15'h0000
`define PRLK_DBGRUN_RST  15'h0000
`define PRLK_STAT_LOCKED 32'h00000000
`define PRLK_STAT_HALF   32'h00000001
`define PRLK_STAT_OPEN   32'h00000002
`define PRLK_RDATA_ZERO  32'h00000000

`endif

// ===== hw/prlk_pkg.sv
`include "prlk_params.svh"

package prlk_pkg;

  typedef logic [`PRLK_ADDR_W-1:0] prlk_addr_t;
  typedef logic [`PRLK_DATA_W-1:0] prlk_data_t;
  typedef logic [`PRLK_NGRP-1:0]   prlk_grp_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    prlk_addr_t addr;
    prlk_data_t wdata;
  } prlk_req_s;

  typedef enum logic [1:0] {
    KEY_LOCKED,
    KEY_HALF,
    KEY_OPEN
  } prlk_key_state_e;

endpackage

// ===== hw/prlk_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "prlk_params.svh"

module prlk_top
  import prlk_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       RESETN_I,
  input  wire prlk_req_s  REQ_I,
  input  wire logic       DBG_HALT_I,
  output prlk_req_s       PERIPH_REQ_O,
  output logic            RSP_VALID_O,
  output prlk_data_t      RSP_RDATA_O,
  output logic            WRITE_DROP_O,
  output prlk_grp_t       LOCK_MASK_O,
  output prlk_grp_t       FREEZE_O
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_self(input prlk_addr_t a);
    is_self = (a[`PRLK_SLOT_HI:`PRLK_SLOT_LO] == `PRLK_SLOT_SELF);
  endfunction

  // slot n maps to lock bit n; the unit's own slot has no bit
  function automatic logic slot_locked(input prlk_addr_t a, input prlk_grp_t m);
    logic [`PRLK_SLOT_W-1:0] s;
    s = a[`PRLK_SLOT_HI:`PRLK_SLOT_LO];
    if (s == `PRLK_SLOT_SELF) begin
      slot_locked = 1'b0;
    end else begin
      slot_locked = m[s];
    end
  endfunction

  prlk_grp_t         lock_mask_reg;
  prlk_grp_t         dbg_run_reg;
  prlk_req_s         periph_req_reg;
  logic              rsp_valid_reg;
  prlk_data_t        rsp_rdata_reg;
  logic              write_drop_reg;
  prlk_grp_t         freeze_reg;
  logic              unlocked;
  prlk_data_t        key_status;
  logic              self_acc;
  logic              self_wr;
  logic              key_wr;
  logic              mask_wr;
  logic              dbgrun_wr;
  logic              periph_wr_lock;
  logic [`PRLK_OFS_HI:0] ofs;

  assign ofs            = REQ_I.addr[`PRLK_OFS_HI:`PRLK_OFS_LO];
  assign self_acc       = REQ_I.valid && is_self(REQ_I.addr);
  assign self_wr        = self_acc && REQ_I.write;
  assign key_wr         = self_wr && (ofs == `PRLK_OFS_KEY);
  assign mask_wr        = self_wr && (ofs == `PRLK_OFS_MASK);
  assign dbgrun_wr      = self_wr && (ofs == `PRLK_OFS_DBGRUN);
  assign periph_wr_lock = REQ_I.valid && REQ_I.write
                          && slot_locked(REQ_I.addr, lock_mask_reg);

  // ----------------------------------------------------------------
  // key sequence
  // ----------------------------------------------------------------
  prlk_key_seq u_key_seq (
    .clk_i      (CLK_I),
    .resetn_i   (RESETN_I),
    .key_wr_i   (key_wr),
    .key_data_i (REQ_I.wdata),
    .unlocked_o (unlocked),
    .status_o   (key_status)
  );

  // ----------------------------------------------------------------
  // protected configuration
  // ----------------------------------------------------------------
  // the debug-run choices sit behind the same key so a runaway
  // program cannot unfreeze peripherals either
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      lock_mask_reg <= `PRLK_MASK_RST;
    end else if (mask_wr && unlocked) begin
      lock_mask_reg <= REQ_I.wdata[`PRLK_NGRP-1:0];
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      dbg_run_reg <= `PRLK_DBGRUN_RST;
    end else if (dbgrun_wr && unlocked) begin
      dbg_run_reg <= REQ_I.wdata[`PRLK_NGRP-1:0];
    end
  end

  // ----------------------------------------------------------------
  // peripheral access path
  // ----------------------------------------------------------------
  // one cycle of latency buys a flop-driven peripheral request
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      periph_req_reg <= '0;
    end else begin
      periph_req_reg.valid <= REQ_I.valid && !is_self(REQ_I.addr)
                              && !periph_wr_lock;
      periph_req_reg.write <= REQ_I.write;
      periph_req_reg.addr  <= REQ_I.addr;
      periph_req_reg.wdata <= REQ_I.wdata;
    end
  end

  // a refused write to the lock registers counts as a drop too
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      write_drop_reg <= 1'b0;
    end else begin
      write_drop_reg <= periph_wr_lock
                        || ((mask_wr || dbgrun_wr) && !unlocked);
    end
  end

  // ----------------------------------------------------------------
  // own register answers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rsp_valid_reg <= 1'b0;
      rsp_rdata_reg <= `PRLK_RDATA_ZERO;
    end else begin
      rsp_valid_reg <= self_acc;
      if (!self_acc || REQ_I.write) begin
        rsp_rdata_reg <= `PRLK_RDATA_ZERO;
      end else if (ofs == `PRLK_OFS_KEY) begin
        rsp_rdata_reg <= key_status;
      end else if (ofs == `PRLK_OFS_MASK) begin
        rsp_rdata_reg <= {{(`PRLK_DATA_W-`PRLK_NGRP){1'b0}}, lock_mask_reg};
      end else if (ofs == `PRLK_OFS_DBGRUN) begin
        rsp_rdata_reg <= {{(`PRLK_DATA_W-`PRLK_NGRP){1'b0}}, dbg_run_reg};
      end else begin
        rsp_rdata_reg <= `PRLK_RDATA_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // debug freeze
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PRLK_NGRP; g = g + 1) begin : gen_freeze
      always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
          freeze_reg[g] <= 1'b0;
        end else begin
          freeze_reg[g] <= DBG_HALT_I && !dbg_run_reg[g];
        end
      end
    end
  endgenerate

  assign PERIPH_REQ_O = periph_req_reg;
  assign RSP_VALID_O  = rsp_valid_reg;
  assign RSP_RDATA_O  = rsp_rdata_reg;
  assign WRITE_DROP_O = write_drop_reg;
  assign LOCK_MASK_O  = lock_mask_reg;
  assign FREEZE_O     = freeze_reg;

endmodule
`default_nettype wire

// ===== testbench/prlk_chk.sv
`timescale 1ns/100ps
`default_nettype none
module prlk_chk
  import prlk_pkg::*;
(
  input wire logic       CLK_I,
  input wire logic       RESETN_I,
  input wire prlk_req_s  REQ_I,
  input wire logic       DBG_HALT_I,
  input wire prlk_req_s  PERIPH_REQ_O,
  input wire logic       RSP_VALID_O,
  input wire prlk_data_t RSP_RDATA_O,
  input wire logic       WRITE_DROP_O,
  input wire prlk_grp_t  LOCK_MASK_O,
  input wire prlk_grp_t  FREEZE_O
);
  // ----------------------------------------
  // access checks
  // ----------------------------------------
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  logic self;
  logic lkd;
  assign self = REQ_I.valid && REQ_I.addr[15:12] == 4'hf;
  // self guards the index: slot f has no mask bit
  assign lkd = REQ_I.valid && REQ_I.write && !self && LOCK_MASK_O[REQ_I.addr[15:12]];
  a_locked_drop: assert property (lkd |=> WRITE_DROP_O && !PERIPH_REQ_O.valid)
    else $error("locked write not dropped");
  a_read_pass: assert property (REQ_I.valid && !REQ_I.write && !self
    |=> PERIPH_REQ_O.valid && PERIPH_REQ_O.addr == $past(REQ_I.addr))
    else $error("read not forwarded");
  a_open_fwd: assert property (REQ_I.valid && !self && !lkd |=> PERIPH_REQ_O.valid)
    else $error("open access not forwarded");
  a_self_rsp: assert property (self |=> RSP_VALID_O && !PERIPH_REQ_O.valid)
    else $error("own access not answered");
  a_rsp_cause: assert property (RSP_VALID_O |-> $past(self))
    else $error("answer without own access");
  a_wr_rdata: assert property (self && REQ_I.write |=> RSP_RDATA_O == 32'h0)
    else $error("write answer data not zero");
  a_mask_cause: assert property ($changed(LOCK_MASK_O)
    |-> $past(REQ_I.valid && REQ_I.write && REQ_I.addr == 16'hf004))
    else $error("mask changed without mask write");
  a_freeze_idle: assert property (!$past(DBG_HALT_I) |-> FREEZE_O == 15'h0)
    else $error("freeze without halt");
  a_drop_cause: assert property (WRITE_DROP_O |-> $past(REQ_I.valid && REQ_I.write))
    else $error("drop without write");
  c_locked: cover property (lkd);
  c_open: cover property (RSP_VALID_O && RSP_RDATA_O == 32'h2);
  c_freeze: cover property (FREEZE_O != 15'h0);
endmodule
bind prlk_top prlk_chk prlk_chk_i (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .REQ_I(REQ_I),
  .DBG_HALT_I(DBG_HALT_I), .PERIPH_REQ_O(PERIPH_REQ_O), .RSP_VALID_O(RSP_VALID_O),
  .RSP_RDATA_O(RSP_RDATA_O), .WRITE_DROP_O(WRITE_DROP_O), .LOCK_MASK_O(LOCK_MASK_O),
  .FREEZE_O(FREEZE_O));
`default_nettype wire

// ===== testbench/prlk_fw.sv
`timescale 1ns/100ps
`default_nettype none
module prlk_fw
  import prlk_pkg::*;
(
  input  wire logic     clk_i,
  output var prlk_req_s req_o
);
  // ----------------------------------------
  // firmware access model
  // ----------------------------------------
  initial req_o = '0;
  task automatic acc(input logic w, input prlk_addr_t a, input prlk_data_t d);
    @(posedge clk_i);
    req_o <= '{1'h1, w, a, d};
  endtask
  // fields inverted when idle so stale values never look valid
  task automatic idle();
    @(posedge clk_i);
    req_o <= '{1'h0, ~req_o.write, ~req_o.addr, ~req_o.wdata};
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "prlk_params.svh"
module tb
  import prlk_pkg::*;
;
  // ----------------------------------------
  // bench
  // ----------------------------------------
  localparam logic [2:0] RSP = 3'h4, DRP = 3'h6, LKD = 3'h2, FWD = 3'h1;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        halt = 1'h0;
  prlk_req_s   req, pq;
  logic        rv, wd;
  prlk_data_t  rd, m, d;
  prlk_grp_t   lm, fz;
  int          mismatches = 0;
  int          comparisons = 0;
  logic [34:0] exp_q[$];
  always #4 clk = ~clk;
  prlk_top prlk_top_i (.CLK_I(clk), .RESETN_I(rst_n), .REQ_I(req), .DBG_HALT_I(halt),
    .PERIPH_REQ_O(pq), .RSP_VALID_O(rv), .RSP_RDATA_O(rd), .WRITE_DROP_O(wd),
    .LOCK_MASK_O(lm), .FREEZE_O(fz));
  prlk_fw prlk_fw_i (.clk_i(clk), .req_o(req));
  task automatic report_and_stop();
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp_r(input logic [34:0] e, input logic [34:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL access exp %h got %h", e, s);
    end
  endtask
  task automatic cmp_l(input string n, input prlk_grp_t e, input prlk_grp_t s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic ac(logic w, prlk_addr_t a, prlk_data_t dt, logic [2:0] f, prlk_data_t e);
    exp_q.push_back({f, e});
    prlk_fw_i.acc(w, a, dt);
  endtask
  task automatic settle();
    prlk_fw_i.idle();
    @(negedge clk);
  endtask
  task automatic unlock();
    ac(1'h1, 16'hf000, `PRLK_KEY_FIRST, RSP, 32'h0);
    ac(1'h0, 16'hf000, 32'h0, RSP, `PRLK_STAT_HALF);
    ac(1'h1, 16'hf000, `PRLK_KEY_SECOND, RSP, 32'h0);
    ac(1'h0, 16'hf000, 32'h0, RSP, `PRLK_STAT_OPEN);
  endtask
  // an empty queue yields zero, which never matches a real result
  always @(negedge clk)
    if (rv | wd | pq.valid)
      cmp_r(exp_q.size() ? exp_q.pop_front() : 35'h0,
        {rv, wd, pq.valid, pq.valid ? pq.wdata : rd});
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    void'($urandom(34));
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    ac(1'h0, 16'hf000, 32'h0, RSP, `PRLK_STAT_LOCKED);
    ac(1'h1, 16'hf004, 32'h7fff, DRP, 32'h0);
    d = $urandom;
    ac(1'h1, {4'($urandom_range(14)), 12'h010}, d, FWD, d);
    unlock();
    m = $urandom;
    ac(1'h1, 16'hf004, m, RSP, 32'h0);
    ac(1'h0, 16'hf000, 32'h0, RSP, `PRLK_STAT_OPEN);
    settle();
    cmp_l("mask", m[14:0], lm);
    for (int n = 0; n < 15; n++) begin
      d = $urandom;
      ac(1'h1, {4'(n), 12'h020}, d, m[n] ? LKD : FWD, m[n] ? 32'h0 : d);
      ac(1'h0, {4'(n), 12'h020}, d, FWD, d);
    end
    ac(1'h1, 16'hf000, $urandom, RSP, 32'h0);
    ac(1'h0, 16'hf000, 32'h0, RSP, `PRLK_STAT_LOCKED);
    ac(1'h1, 16'hf004, ~m, DRP, 32'h0);
    ac(1'h1, 16'hf000, `PRLK_KEY_FIRST, RSP, 32'h0);
    ac(1'h1, 16'hf000, 32'h33, RSP, 32'h0);
    ac(1'h1, 16'hf000, `PRLK_KEY_SECOND, RSP, 32'h0);
    ac(1'h0, 16'hf000, 32'h0, RSP, `PRLK_STAT_LOCKED);
    settle();
    cmp_l("mask", m[14:0], lm);
    unlock();
    d = $urandom;
    ac(1'h1, 16'hf008, d, RSP, 32'h0);
    settle();
    @(posedge clk) halt <= 1'h1;
    settle();
    cmp_l("freeze", ~d[14:0], fz);
    settle();
    cmp_l("pending", 15'h0, 15'(exp_q.size()));
    report_and_stop();
  end
endmodule
`default_nettype wire
